// ---- rtl/pit_pkg.sv ----
// constants, types and helper functions for the interval timer block
//=====================================================================
package pit_pkg;

  //===================================================================
  // port addresses
  localparam logic [7:0] PIT_ADDR_CNT0  = 8'h40; // counter zero count
  localparam logic [7:0] PIT_ADDR_CNT2  = 8'h42; // counter two count
  localparam logic [7:0] PIT_ADDR_CTRL  = 8'h43; // shared control
  localparam logic [7:0] PIT_ADDR_CNT3  = 8'h44; // third counter count
  localparam logic [7:0] PIT_ADDR_CTRL3 = 8'h47; // third counter control

  //===================================================================
  // control byte field codes
  localparam logic [1:0] PIT_SEL_A  = 2'h0; // counter zero / third
  localparam logic [1:0] PIT_SEL_B  = 2'h2; // counter two
  localparam logic [1:0] PIT_RW_LAT = 2'h0; // latch command
  localparam logic [1:0] PIT_RW_LSB = 2'h1; // low byte only
  localparam logic [1:0] PIT_RW_MSB = 2'h2; // high byte only
  localparam logic [1:0] PIT_RW_WRD = 2'h3; // low then high
  localparam logic [2:0] PIT_MD_0   = 3'h0; // terminal count
  localparam logic [2:0] PIT_MD_1   = 3'h1; // one-shot
  localparam logic [1:0] PIT_MD_2LO = 2'h2; // rate gen, bit 3 ignored

  //===================================================================
  // channel layout: slot 0 counter zero, 1 counter two, 2 third
  localparam int PIT_NCH   = 3;
  localparam int PIT_CH_B  = 1; // the only slot allowed mode 1
  localparam int PIT_CH_C  = 2; // narrow binary mode-0 slot
  localparam logic [15:0] PIT_ONE  = 16'h0001;
  localparam logic [15:0] PIT_ZERO = 16'h0000;

  // control byte as written
  typedef struct packed {
    logic [1:0] sel;  // counter select
    logic [1:0] rw;   // access format
    logic [2:0] mode; // operating mode
    logic       bcd;  // decimal counting
  } pit_ctrl_s;

  localparam pit_ctrl_s PIT_CTRL_RST = '{PIT_SEL_A, PIT_RW_LSB,
                                         PIT_MD_0, 1'b0};

  // behaviour class of a channel
  typedef enum logic [1:0] {PIT_M0, PIT_M1, PIT_M2, PIT_MX} pit_mode_e;

  // mode field to behaviour; unsupported modes idle with out high
  function automatic pit_mode_e pit_mode(input logic [2:0] m,
                                         input logic       one_ok);
    pit_mode_e r;
    r = PIT_MX;
    if (m == PIT_MD_0)
      r = PIT_M0;
    else if (m == PIT_MD_1 && one_ok)
      r = PIT_M1;
    else if (m[1:0] == PIT_MD_2LO)
      r = PIT_M2;
    return r;
  endfunction

  // one down step: binary, four-digit decimal, or 8-bit narrow
  function automatic logic [15:0] pit_dec(input logic [15:0] v,
                                          input logic        bcd,
                                          input logic        narrow);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (narrow) begin
      r = {8'h00, v[7:0] - 8'h01};
    end else if (!bcd) begin
      r = v - PIT_ONE;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (borrow) begin
          if (v[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = 4'h9;
          end else begin
            r[4*k +: 4] = v[4*k +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

endpackage

// ---- rtl/pit_timer.sv ----
// interval timer: three counters behind five byte-wide i/o ports
`timescale 1ns/1ns
module pit_timer
  import pit_pkg::*;
#(
  parameter int CNT_W   = 16, // width of counters zero and two
  parameter int SMALL_W = 8   // width of the third counter
) (
  input  wire logic       clk,       // system clock, 20 MHz
  input  wire logic       rst,       // synchronous reset, high
  input  wire logic [7:0] io_addr,   // i/o port address
  input  wire logic       io_wr,     // write strobe, one cycle
  input  wire logic       io_rd,     // read strobe, one cycle
  input  wire logic [7:0] io_wdata,  // write data
  output logic      [7:0] io_rdata,  // read data, cycle after io_rd
  input  wire logic [2:0] tmr_clk,   // counter clock pins
  input  wire logic [2:0] tmr_gate,  // count enable pins
  output logic      [2:0] tmr_out    // counter outputs
);

  //===================================================================
  // elaboration checks
  if (CNT_W != 16 || SMALL_W != 8) begin : g_bad_width
    $error("pit_timer supports only 16-bit and 8-bit counters");
  end

  //===================================================================
  // port decode
  pit_ctrl_s   wctl;                    // write data seen as control
  logic        wr_ctrl;                 // write to shared control
  logic        wr_ctrl3;                // write to third control
  logic [2:0]  ctl_hit;                 // control aimed at channel
  logic [2:0]  cmd_prog;                // programming byte
  logic [2:0]  cmd_latch;               // latch command
  logic [2:0]  cnt_wr;                  // count port write
  logic [2:0]  cnt_rd;                  // count port read
  logic [7:0]  rd_byte [PIT_NCH];       // byte each channel offers
  logic [7:0]  rdata_d;                 // next read data

  assign wctl     = pit_ctrl_s'(io_wdata);
  assign wr_ctrl  = io_wr && io_addr == PIT_ADDR_CTRL;
  assign wr_ctrl3 = io_wr && io_addr == PIT_ADDR_CTRL3;
  // reserved selects reach no channel
  assign ctl_hit[0] = wr_ctrl && wctl.sel == PIT_SEL_A;
  assign ctl_hit[1] = wr_ctrl && wctl.sel == PIT_SEL_B;
  // third port: select 00, latch or low byte only
  assign ctl_hit[2] = wr_ctrl3 && wctl.sel == PIT_SEL_A
                   && (wctl.rw == PIT_RW_LAT
                       || wctl.rw == PIT_RW_LSB);
  assign cmd_latch = ctl_hit & {3{wctl.rw == PIT_RW_LAT}};
  assign cmd_prog  = ctl_hit & {3{wctl.rw != PIT_RW_LAT}};

  // count port of a slot
  function automatic logic [7:0] port_of(input int ch);
    logic [7:0] a;
    a = PIT_ADDR_CNT3;
    if (ch == 0)
      a = PIT_ADDR_CNT0;
    else if (ch == PIT_CH_B)
      a = PIT_ADDR_CNT2;
    return a;
  endfunction

  //===================================================================
  // per-channel state
  logic        clk_r_q   [PIT_NCH]; // sampled counter clock
  logic        gate_r_q  [PIT_NCH]; // enable taken at clock rise
  logic        trig_q    [PIT_NCH]; // rising enable seen at rise
  pit_ctrl_s   ctl_q     [PIT_NCH]; // programmed control
  pit_mode_e   mode_q    [PIT_NCH]; // behaviour class
  logic [15:0] cnt_q     [PIT_NCH]; // counting element
  logic [15:0] init_q    [PIT_NCH]; // count register
  logic [15:0] latch_q   [PIT_NCH]; // output latch snapshot
  logic        latched_q [PIT_NCH]; // latch frozen
  logic        wptr_q    [PIT_NCH]; // word write: high byte next
  logic        rptr_q    [PIT_NCH]; // word read: high byte next
  logic        new_q     [PIT_NCH]; // count written, not loaded
  logic        armed_q   [PIT_NCH]; // a count was written
  logic        run_q     [PIT_NCH]; // element holds a count
  logic        halt_q    [PIT_NCH]; // mode 0 half-written word
  logic        out_q     [PIT_NCH]; // counter output
  logic        fall_w    [PIT_NCH]; // falling counter clock
  logic        rdlast_w  [PIT_NCH]; // read completes the value

  for (genvar i = 0; i < PIT_NCH; i++) begin : g_ch
    localparam bit NARROW = (i == PIT_CH_C);
    logic        rise;     // rising counter clock
    logic [15:0] dec_v;    // count after one step
    logic [15:0] src;      // latch or live count
    logic        rd_hi;    // read hands out high byte
    logic        wr_hi;    // write fills high byte
    logic        wr_done;  // write completes the count
    pit_ctrl_s   new_ctl;  // control as stored

    // edges from the pin sampled on the system clock
    assign rise      = !clk_r_q[i] && tmr_clk[i];
    assign fall_w[i] = clk_r_q[i] && !tmr_clk[i];
    assign cnt_wr[i] = io_wr && io_addr == port_of(i);
    assign cnt_rd[i] = io_rd && io_addr == port_of(i);
    assign dec_v     = pit_dec(cnt_q[i], ctl_q[i].bcd, NARROW);
    assign src       = latched_q[i] ? latch_q[i] : cnt_q[i];
    assign rd_hi     = ctl_q[i].rw == PIT_RW_MSB
                    || (ctl_q[i].rw == PIT_RW_WRD && rptr_q[i]);
    assign rd_byte[i] = rd_hi ? src[15:8] : src[7:0];
    assign rdlast_w[i] = ctl_q[i].rw != PIT_RW_WRD || rptr_q[i];
    assign wr_hi     = ctl_q[i].rw == PIT_RW_MSB
                    || (ctl_q[i].rw == PIT_RW_WRD && wptr_q[i]);
    assign wr_done   = ctl_q[i].rw != PIT_RW_WRD || wptr_q[i];
    // third counter is fixed to binary mode 0, low byte
    assign new_ctl   = NARROW
                     ? pit_ctrl_s'{PIT_SEL_A, wctl.rw, PIT_MD_0, 1'b0}
                     : wctl;
    assign tmr_out[i] = out_q[i];

    // gate sampling happens only on counter clock rises
    always_ff @(posedge clk) begin
      if (rst) begin
        clk_r_q[i]  <= 1'b0;
        gate_r_q[i] <= 1'b0;
        trig_q[i]   <= 1'b0;
      end else begin
        clk_r_q[i] <= tmr_clk[i];
        if (rise) begin
          gate_r_q[i] <= tmr_gate[i];
          trig_q[i]   <= tmr_gate[i] && !gate_r_q[i];
        end
      end
    end

    // counting, host accesses; later statements win the cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        ctl_q[i]     <= PIT_CTRL_RST;
        mode_q[i]    <= PIT_MX;
        cnt_q[i]     <= PIT_ZERO;
        init_q[i]    <= PIT_ZERO;
        latch_q[i]   <= PIT_ZERO;
        latched_q[i] <= 1'b0;
        wptr_q[i]    <= 1'b0;
        rptr_q[i]    <= 1'b0;
        new_q[i]     <= 1'b0;
        armed_q[i]   <= 1'b0;
        run_q[i]     <= 1'b0;
        halt_q[i]    <= 1'b0;
        out_q[i]     <= 1'b1;
      end else begin
        // counter clock falling edge
        if (fall_w[i]) begin
          unique case (mode_q[i])
            PIT_M0: begin
              if (new_q[i]) begin
                // load without a step
                cnt_q[i]  <= init_q[i];
                new_q[i]  <= 1'b0;
                run_q[i]  <= 1'b1;
                halt_q[i] <= 1'b0;
              end else if (run_q[i] && !halt_q[i]
                           && gate_r_q[i]) begin
                cnt_q[i] <= dec_v;
                if (dec_v == PIT_ZERO)
                  out_q[i] <= 1'b1;
              end
            end
            PIT_M1: begin
              if (trig_q[i] && armed_q[i]) begin
                // retrigger takes whatever count is armed
                cnt_q[i] <= init_q[i];
                out_q[i] <= 1'b0;
                new_q[i] <= 1'b0;
              end else begin
                cnt_q[i] <= dec_v;
                if (!out_q[i] && cnt_q[i] == PIT_ONE)
                  out_q[i] <= 1'b1;
              end
            end
            PIT_M2: begin
              if ((new_q[i] && !run_q[i])
                  || (trig_q[i] && armed_q[i])) begin
                cnt_q[i] <= init_q[i];
                out_q[i] <= 1'b1;
                run_q[i] <= 1'b1;
                new_q[i] <= 1'b0;
              end else if (run_q[i] && gate_r_q[i]) begin
                if (cnt_q[i] == PIT_ONE) begin
                  // cycle end: reload, pick up a pending count
                  cnt_q[i] <= init_q[i];
                  out_q[i] <= 1'b1;
                  new_q[i] <= 1'b0;
                end else begin
                  cnt_q[i] <= dec_v;
                  out_q[i] <= dec_v != PIT_ONE;
                end
              end
            end
            default: begin
              out_q[i] <= 1'b1;
            end
          endcase
        end
        // snapshot only if not already frozen
        if (cmd_latch[i] && !latched_q[i]) begin
          latch_q[i]   <= cnt_q[i];
          latched_q[i] <= 1'b1;
        end
        // reads walk the pointer; last byte releases the latch
        if (cnt_rd[i]) begin
          if (ctl_q[i].rw == PIT_RW_WRD)
            rptr_q[i] <= !rptr_q[i];
          if (rdlast_w[i])
            latched_q[i] <= 1'b0;
        end
        // count writes fill the count register
        if (cnt_wr[i]) begin
          if (wr_hi)
            init_q[i][15:8] <= io_wdata;
          else
            init_q[i][7:0] <= io_wdata;
          if (ctl_q[i].rw == PIT_RW_LSB)
            init_q[i][15:8] <= 8'h00;
          if (ctl_q[i].rw == PIT_RW_MSB)
            init_q[i][7:0] <= 8'h00;
          if (ctl_q[i].rw == PIT_RW_WRD)
            wptr_q[i] <= !wptr_q[i];
          if (mode_q[i] == PIT_M0) begin
            out_q[i] <= 1'b0;
            if (!wr_done)
              halt_q[i] <= 1'b1;
          end
          if (wr_done) begin
            new_q[i]   <= 1'b1;
            armed_q[i] <= 1'b1;
          end
        end
        // mode 2: enable low forces out high, ending any low pulse
        if (mode_q[i] == PIT_M2 && !tmr_gate[i])
          out_q[i] <= 1'b1;
        // a control byte clears flags and pointers but not the counts, no clock pulse
        if (cmd_prog[i]) begin
          ctl_q[i]     <= new_ctl;
          mode_q[i]    <= pit_mode(new_ctl.mode,
                                   i == PIT_CH_B);
          out_q[i]     <= new_ctl.mode != PIT_MD_0;
          latched_q[i] <= 1'b0;
          wptr_q[i]    <= 1'b0;
          rptr_q[i]    <= 1'b0;
          new_q[i]     <= 1'b0;
          armed_q[i]   <= 1'b0;
          run_q[i]     <= 1'b0;
          halt_q[i]    <= 1'b0;
        end
      end
    end
  end

  //===================================================================
  // read data, registered one cycle after the strobe
  assign rdata_d = cnt_rd[0] ? rd_byte[0] :
                   cnt_rd[1] ? rd_byte[1] :
                   cnt_rd[2] ? rd_byte[2] : 8'h00;

  // unmapped or write-only ports read as zero
  always_ff @(posedge clk) begin
    if (rst)
      io_rdata <= 8'h00;
    else if (io_rd)
      io_rdata <= rdata_d;
  end

  //===================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_LATCH_HOLD: assert property (
    latched_q[0] && !cnt_rd[0] && !cmd_prog[0]
    |=> latched_q[0] && $stable(latch_q[0]))
    else $error("latched count changed before read");

  AST_LATCH_IGNORE: assert property (
    latched_q[0] && cmd_latch[0] && !cnt_rd[0]
    |=> latch_q[0] == $past(latch_q[0]))
    else $error("second latch command overwrote snapshot");

  AST_UNLATCH: assert property (
    latched_q[0] && cnt_rd[0] && rdlast_w[0] && !cmd_latch[0]
    |=> !latched_q[0] && (io_rdata == $past(latch_q[0][7:0])
        || io_rdata == $past(latch_q[0][15:8])))
    else $error("latch not released after full read");

  AST_M0_CTRL_LOW: assert property (
    cmd_prog[0] && wctl.mode == PIT_MD_0 |=> !tmr_out[0])
    else $error("mode 0 control byte left out high");

  AST_M0_LOAD: assert property (
    mode_q[1] == PIT_M0 && new_q[1] && fall_w[1]
    && !cnt_wr[1] && !cmd_prog[1]
    |=> cnt_q[1] == $past(init_q[1]) && !new_q[1])
    else $error("mode 0 count not loaded on clock pulse");

  AST_M0_GATE: assert property (
    mode_q[0] == PIT_M0 && !gate_r_q[0] && !new_q[0]
    && !cmd_prog[0]
    |=> $stable(cnt_q[0]))
    else $error("mode 0 counted with enable low");

  AST_M2_PULSE: assert property (
    mode_q[1] == PIT_M2 && run_q[1] && cnt_q[1] == PIT_ONE
    && fall_w[1] && gate_r_q[1] && !trig_q[1] && !cmd_prog[1]
    && !cnt_wr[1]
    |=> tmr_out[1] && cnt_q[1] == $past(init_q[1]))
    else $error("mode 2 did not reload at end of cycle");

  AST_M2_GATE: assert property (
    mode_q[1] == PIT_M2 && !tmr_gate[1] && !cmd_prog[1]
    |=> tmr_out[1])
    else $error("mode 2 out not forced high on enable low");

  AST_CTRL_CLEAR: assert property (
    cmd_prog[1] |=> !latched_q[1] && !new_q[1] && !wptr_q[1]
                    && !rptr_q[1])
    else $error("control byte did not clear counter state");

  AST_SEL_RSVD: assert property (
    wr_ctrl && wctl.sel[0] |-> cmd_prog == 3'h0
    && cmd_latch == 3'h0)
    else $error("reserved select reached a counter");

  AST_M1_ONLY_B: assert property (
    cmd_prog[0] && wctl.mode == PIT_MD_1 |=> mode_q[0] == PIT_MX)
    else $error("mode 1 accepted on counter zero");

  AST_NARROW_BIN: assert property (
    cmd_prog[2] |=> !ctl_q[2].bcd && cnt_q[2][15:8] == 8'h00)
    else $error("third counter left binary 8-bit form");

  COV_LATCH_READ: cover property (
    cmd_latch[0] ##[1:20] cnt_rd[0] && rdlast_w[0]);
  COV_M0_EXPIRE: cover property (
    mode_q[0] == PIT_M0 && !tmr_out[0] ##1 tmr_out[0]);
  COV_M1_SHOT: cover property (
    mode_q[1] == PIT_M1 && tmr_out[1] ##1 !tmr_out[1]);
  COV_M2_PULSE: cover property (
    mode_q[1] == PIT_M2 && !tmr_out[1] ##1 tmr_out[1]);

endmodule

// ---- verif/pit_host_model.sv ----
// host processor model issuing i/o port cycles to the timer
`timescale 1ns/1ns
module pit_host_model (
  input  wire logic       clk,      // system clock
  output logic      [7:0] io_addr,  // port address
  output logic            io_wr,    // write strobe
  output logic            io_rd,    // read strobe
  output logic      [7:0] io_wdata, // write data
  input  wire logic [7:0] io_rdata  // read data from the timer
);
  //==================================================================
  // idle bus; addr and data toggle so stale values never look valid
  initial begin
    io_addr  = 8'hFF;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'hA5;
  end

  //==================================================================
  // one write cycle; strobe held exactly one clock
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr    <= 1'b0;
    io_addr  <= ~a;  // released lines show the inverse
    io_wdata <= ~d;
  endtask

  //==================================================================
  // one read cycle; data taken the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd   <= 1'b0;
    io_addr <= ~a;
    @(posedge clk);
    #1;
    d = io_rdata;
  endtask
endmodule

// ---- verif/test_pit_timer.sv ----
// self-checking bench for the interval timer
`timescale 1ns/1ns
module test_pit_timer;
  import pit_pkg::*;
  logic       clk = 1'b0;       // 20 MHz system clock
  logic       rst = 1'b1;       // synchronous reset
  logic [7:0] io_addr;          // from host model
  logic       io_wr;            // from host model
  logic       io_rd;            // from host model
  logic [7:0] io_wdata;         // from host model
  logic [7:0] io_rdata;         // from timer
  logic [2:0] tmr_clk = 3'h0;   // counter clocks
  logic [2:0] tmr_gate = 3'h0;  // count enables
  logic [2:0] tmr_out;          // counter outputs
  int         fail_count = 0;   // mismatches seen
  int         checked = 0;      // comparisons made
  integer     seed = 16;        // fixed seed, repeatable run
  int         n;                // random count
  int         k;                // pulses seen
  logic [15:0] w;               // wide random count
  logic [7:0] lo, hi;           // read bytes

  always #25 clk = ~clk;

  pit_timer dut_u (.clk(clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .tmr_clk(tmr_clk), .tmr_gate(tmr_gate),
    .tmr_out(tmr_out));

  pit_host_model host_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

  //==================================================================
  // comparison and verdict
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //==================================================================
  // expectations: mode 0 needs a load pulse before counting
  function automatic int exp_m0(input int c);
    return c + 1;
  endfunction

  //==================================================================
  // one counter clock pulse, slow enough for pin sampling
  task automatic pulse(input int ch);
    @(posedge clk) tmr_clk[ch] <= 1'b1;
    repeat (2) @(posedge clk);
    tmr_clk[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // pulses until an output reaches a level, bounded
  task automatic run_until(input int ch, input logic lv, output int c);
    c = 0;
    while (tmr_out[ch] !== lv && c < 40) begin
      pulse(ch);
      c++;
    end
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // latch then read a word from a count port
  task automatic latch_rd(input logic [7:0] cmd, input logic [7:0] a);
    host_u.wr(PIT_ADDR_CTRL, cmd);
    host_u.rd(a, lo);
    host_u.rd(a, hi);
  endtask

  //==================================================================
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    #(50 * 40000);
    fail_count++;
    report_and_stop();
  end

  //==================================================================
  // main sequence; control bytes always precede counts
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    check(tmr_out, 3'h7);
    check(io_rdata, 8'h00);
    // counter zero word access, gate low: load but no count
    w = $random(seed);
    host_u.wr(PIT_ADDR_CTRL, 8'h30);
    host_u.wr(PIT_ADDR_CNT0, w[7:0]);
    host_u.wr(PIT_ADDR_CNT0, w[15:8]);
    repeat (3) pulse(0);
    check(tmr_out[0], 1'b0);
    host_u.wr(PIT_ADDR_CTRL, 8'h00);
    tmr_gate[0] <= 1'b1;
    repeat (2) pulse(0);
    latch_rd(8'h00, PIT_ADDR_CNT0);
    check({hi, lo}, w);
    latch_rd(8'h00, PIT_ADDR_CNT0);
    check({hi, lo}, w - 16'h0002);
    // first byte of a word halts counting until the second lands
    host_u.wr(PIT_ADDR_CNT0, 8'h05);
    pulse(0);
    check(tmr_out[0], 1'b0);
    latch_rd(8'h00, PIT_ADDR_CNT0);
    check({hi, lo}, w - 16'h0002);
    host_u.wr(PIT_ADDR_CNT0, 8'h00);
    pulse(0);
    latch_rd(8'h00, PIT_ADDR_CNT0);
    check({hi, lo}, 16'h0005);
    // mode 0 low byte: out low at control, high after n+1
    n = 2 + ({$random(seed)} % 8);
    host_u.wr(PIT_ADDR_CTRL, 8'h10);
    settle();
    check(tmr_out[0], 1'b0);
    host_u.wr(PIT_ADDR_CNT0, n[7:0]);
    run_until(0, 1'b1, k);
    check(k, exp_m0(n));
    host_u.wr(PIT_ADDR_CTRL, 8'h70);
    host_u.wr(PIT_ADDR_CTRL, 8'hF0);
    settle();
    check(tmr_out[0], 1'b1);
    // counter two decimal: 10 minus one is 09
    tmr_gate[1] <= 1'b1;
    host_u.wr(PIT_ADDR_CTRL, 8'hB1);
    host_u.wr(PIT_ADDR_CNT2, 8'h10);
    host_u.wr(PIT_ADDR_CNT2, 8'h00);
    repeat (2) pulse(1);
    latch_rd(8'h80, PIT_ADDR_CNT2);
    check({hi, lo}, 16'h0009);
    // counter two rate generator, bit 3 set and ignored
    n = 2 + ({$random(seed)} % 8);
    host_u.wr(PIT_ADDR_CTRL, 8'h9C);
    host_u.wr(PIT_ADDR_CNT2, n[7:0]);
    run_until(1, 1'b0, k);
    check(k, n);
    pulse(1);
    check(tmr_out[1], 1'b1);
    run_until(1, 1'b0, k);
    // reload pulse already seen, so n-1 more to the low pulse
    check(k, n - 1);
    // count written mid-cycle waits; gate low ends the low pulse
    host_u.wr(PIT_ADDR_CNT2, 8'h03);
    tmr_gate[1] <= 1'b0;
    repeat (3) settle();
    check(tmr_out[1], 1'b1);
    pulse(1);
    tmr_gate[1] <= 1'b1;
    pulse(1);
    run_until(1, 1'b0, k);
    check(k, 16'h0002);
    tmr_gate[1] <= 1'b0;
    // counter two one-shot
    n = 1 + ({$random(seed)} % 8);
    host_u.wr(PIT_ADDR_CTRL, 8'h92);
    host_u.wr(PIT_ADDR_CNT2, n[7:0]);
    pulse(1);
    check(tmr_out[1], 1'b1);
    tmr_gate[1] <= 1'b1;
    pulse(1);
    check(tmr_out[1], 1'b0);
    host_u.wr(PIT_ADDR_CNT2, 8'h0F);
    run_until(1, 1'b1, k);
    check(k, n);
    // only a retrigger picks up the count written mid-pulse
    tmr_gate[1] <= 1'b0;
    pulse(1);
    tmr_gate[1] <= 1'b1;
    pulse(1);
    run_until(1, 1'b1, k);
    check(k, 16'h000F);
    tmr_gate[1] <= 1'b0;
    // one-shot refused on counter zero
    tmr_gate[0] <= 1'b0;
    host_u.wr(PIT_ADDR_CTRL, 8'h12);
    host_u.wr(PIT_ADDR_CNT0, 8'h02);
    pulse(0);
    tmr_gate[0] <= 1'b1;
    repeat (3) pulse(0);
    check(tmr_out[0], 1'b1);
    // third counter, low bits of control written as zero
    n = 2 + ({$random(seed)} % 8);
    host_u.wr(PIT_ADDR_CTRL3, 8'h10);
    tmr_gate[2] <= 1'b1;
    host_u.wr(PIT_ADDR_CNT3, n[7:0]);
    run_until(2, 1'b1, k);
    check(k, exp_m0(n));
    host_u.wr(PIT_ADDR_CTRL3, 8'h50);
    host_u.wr(PIT_ADDR_CTRL3, 8'h20);
    settle();
    check(tmr_out[2], 1'b1);
    // write-only and unmapped ports read as zero
    host_u.rd(PIT_ADDR_CTRL, lo);
    check(lo, 8'h00);
    host_u.rd(8'h41, lo);
    check(lo, 8'h00);
    report_and_stop();
  end
endmodule
